// ---- verilog/sync_cfg.svh ----
/*
  Offsets, field positions, reset values and timing counts of the sync
  processor. Assumes it is included by bare name from the design files.
*/
`ifndef SYNC_CFG_SVH
`define SYNC_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_SEPARATION   2'h0
`define OFS_CLAMP_POL    2'h1
`define OFS_DETECTION    2'h2
`define OFS_PORT_READ    2'h3

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define B0_SRC_SEL       7
`define B0_BLANK_EN      6
`define B0_VOS           5
`define B1_CLAMP_HI      7
`define B1_CLAMP_LO      6
`define B1_PORCH         5
`define B1_CLAMP_POL     4
`define B1_V_INV         3
`define B1_H_INV         2
`define B2_FSYNC_SEL     5
`define B2_PSEUDO_DIS    4
`define B2_OUT_DIS       3
`define B2_SOG           2
`define B2_LATCH_CHG     1
`define B2_VDD_SEL       0
`define REG_RESET        8'h00

// ----------------------------------------------------------------
// Counts
// ----------------------------------------------------------------
`define SEP_MAX          5'h1F
`define SEP_MIN          5'h00
`define FSYNC_DIV3_LAST  2'h2
`define FSYNC_DIV2_LAST  2'h1
`define CLAMP_W1         4'h2
`define CLAMP_W2         4'h4
`define CLAMP_W3         4'h8
`define POL_WIN_LAST     4'hF
`define POL_HALF         5'h08
`define SOG_LAST         6'h3F
`define TIMER_DIV        1000
`define PSEUDO_H_PERIOD  6400
`define PSEUDO_H_WIDTH   760
`define PSEUDO_V_LINES   525
`define PSEUDO_V_WIDTH   2

`endif

// ---- verilog/sync_pkg.sv ----
/*
  Types of the sync processor: its whole state as one packed struct.
  Assumes channel 0 is horizontal, 1 vertical, 2 composite.
*/
package sync_pkg;

  typedef struct packed {
    logic            src_sel;
    logic            blank_en;
    logic            vertical_out_source;
    logic [1:0]      clamp_sel;
    logic            porch;
    logic            clamp_pol;
    logic            v_inv;
    logic            h_inv;
    logic [1:0]      pol;
    logic            unmixed;
    logic            fsync_sel;
    logic            pseudo_dis;
    logic            out_dis;
    logic            green_channel_sync;
    logic            latch_chg;
    logic            vdd_sel;
    logic [4:0]      sep_cnt;
    logic            sep_q;
    logic [1:0]      prescale;
    logic [2:0][2:0] syn;
    logic [2:0]      filt;
    logic            sel_prev;
    logic [3:0]      clamp_cnt;
    logic [15:0]     tmr;
    logic [3:0]      win;
    logic [1:0][4:0] hi_cnt;
    logic [5:0]      sog_cnt;
    logic            c_prev;
    logic [15:0]     ph_cnt;
    logic [15:0]     pv_cnt;
    logic            hsync_o;
    logic            vsync_o;
    logic            clamp_o;
    logic [7:0]      rdata;
  } state_type;

endpackage

// ---- verilog/video_sync_processor.sv ----
/*
  Sync processor of a monitor controller: input select, vertical sync
  separation, clamp pulse, output invert/inhibit, pseudo sync, polarity,
  unmixed-hsync and sync-on-green detection, behind a plain register port.
  Assumes clk_sys is the oscillator clock and sync pins are asynchronous.
*/
`timescale 1ns/100ps
`include "sync_cfg.svh"

// Notes on behaviour
// RL1 - Select bit 0 routes separate hsync input, 1 routes composite input.
// RL2 - Blanking on in composite mode blanks hsync while vsync is extracted.
// RL3 - Vsync out from vsync pin when select 0, from counter latch when 1.
// RL4 - Counter counts up on high samples, down on low, saturating both ends.
// RL5 - Latch goes high at all ones, low at all zeros, holds in between.
// RL6 - Low five bits of the first control register read the counter.
// RL7 - Clamp field 00 inhibits, else pulse of two, four or eight base widths.
// RL8 - Clamp starts after hsync rising edge if porch 0, falling if 1.
// RL9 - Clamp polarity 0 gives active-low pulse, 1 active-high.
// RL10 - Vertical invert bit inverts vsync output when set.
// RL11 - Horizontal invert bit inverts hsync output when set.
// RL12 - Polarity of hsync and vsync found over 16 interval-timer ticks.
// RL13 - Unmixed flag 1 in plain hsync periods, 0 when mixed; read clears. Code holds it 0 while vsync select is 0.
// RL14 - Sampling clock is oscillator over 3 when bit 0, over 2 when 1.
// RL15 - Pseudo-sync disable 0 makes positive pseudo syncs; 1 normal bypass.
// RL16 - Output disable 1 forces sync outputs low.
// RL17 - Green-sync flag shows sync-on-green; writing 0 clears its counter.
// RL18 - Latch-change flag sets on latch change, stays until written 0.
// RL19 - Sync-on-green decided after 64 composite input edges.
// RL20 - All sync pins synchronised before the counters sample them.
module video_sync_processor #(
  parameter int TIMER_DIV       = `TIMER_DIV,
  parameter int PSEUDO_H_PERIOD = `PSEUDO_H_PERIOD,
  parameter int PSEUDO_H_WIDTH  = `PSEUDO_H_WIDTH,
  parameter int PSEUDO_V_LINES  = `PSEUDO_V_LINES,
  parameter int PSEUDO_V_WIDTH  = `PSEUDO_V_WIDTH
) (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       hsync_in,
  input  wire logic       vsync_in,
  input  wire logic       csync_in,
  output logic            hsync_out,
  output logic            vsync_out,
  output logic            clamp_out
);

  localparam logic [15:0] TMR_LAST = 16'(TIMER_DIV - 1);
  localparam logic [15:0] PH_LAST  = 16'(PSEUDO_H_PERIOD - 1);
  localparam logic [15:0] PH_W     = 16'(PSEUDO_H_WIDTH);
  localparam logic [15:0] PV_LAST  = 16'(PSEUDO_V_LINES - 1);
  localparam logic [15:0] PV_W     = 16'(PSEUDO_V_WIDTH);

  sync_pkg::state_type s_q;
  sync_pkg::state_type s_d;

  logic       sel_h;
  logic       samp_tick;
  logic       tmr_tick;
  logic       clamp_start;
  logic       c_edge;
  logic       h_path;
  logic       v_path;
  logic [4:0] tot;
  logic       wr0;
  logic       wr1;
  logic       wr2;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    wr0 = reg_wr && (reg_addr == `OFS_SEPARATION);
    wr1 = reg_wr && (reg_addr == `OFS_CLAMP_POL);
    wr2 = reg_wr && (reg_addr == `OFS_DETECTION);

    // Three-stage chain, level accepted once the last two agree
    for (int ch = 0; ch < 3; ch++) begin
      s_d.syn[ch] = {s_q.syn[ch][1:0], (ch == 0) ? hsync_in :
                     (ch == 1) ? vsync_in : csync_in};                     // RL20
      if (s_q.syn[ch][1] == s_q.syn[ch][2]) begin
        s_d.filt[ch] = s_q.syn[ch][2];                                     // RL20
      end
    end

    sel_h = s_q.src_sel ? s_q.filt[2] : s_q.filt[0];                     // RL1
    s_d.sel_prev = sel_h;

    // Sampling clock prescaler
    samp_tick = (s_q.prescale ==
                 (s_q.fsync_sel ? `FSYNC_DIV2_LAST : `FSYNC_DIV3_LAST));   // RL14
    s_d.prescale = samp_tick ? 2'h0 : s_q.prescale + 2'h1;

    if (samp_tick) begin
      if (sel_h && (s_q.sep_cnt != `SEP_MAX)) begin
        s_d.sep_cnt = s_q.sep_cnt + 5'h01;                                // RL4
      end else if (!sel_h && (s_q.sep_cnt != `SEP_MIN)) begin
        s_d.sep_cnt = s_q.sep_cnt - 5'h01;                                // RL4
      end
    end
    if (s_d.sep_cnt == `SEP_MAX) begin
      s_d.sep_q = 1'b1;                                                   // RL5
    end else if (s_d.sep_cnt == `SEP_MIN) begin
      s_d.sep_q = 1'b0;                                                   // RL5
    end

    // Clamp one-shot; a new edge reloads so the pulse never runs short
    clamp_start = s_q.porch ? (s_q.sel_prev && !sel_h)
                            : (!s_q.sel_prev && sel_h);                   // RL8
    if (clamp_start && (s_q.clamp_sel != 2'h0)) begin
      unique case (s_q.clamp_sel)
        2'h1:    s_d.clamp_cnt = `CLAMP_W1;                               // RL7
        2'h2:    s_d.clamp_cnt = `CLAMP_W2;                               // RL7
        default: s_d.clamp_cnt = `CLAMP_W3;                               // RL7
      endcase
    end else if (s_q.clamp_cnt != 4'h0) begin
      s_d.clamp_cnt = s_q.clamp_cnt - 4'h1;
    end

    // Polarity: mostly-low line carries positive pulses
    tmr_tick = (s_q.tmr == TMR_LAST);
    s_d.tmr = tmr_tick ? 16'h0000 : s_q.tmr + 16'h0001;
    tot = 5'h00;
    if (tmr_tick) begin
      s_d.win = s_q.win + 4'h1;
      for (int ch = 0; ch < 2; ch++) begin
        tot = s_q.hi_cnt[ch] + {4'h0, s_q.filt[ch]};
        if (s_q.win == `POL_WIN_LAST) begin
          s_d.pol[ch] = (tot < `POL_HALF);                                // RL12
          s_d.hi_cnt[ch] = 5'h00;
        end else begin
          s_d.hi_cnt[ch] = tot;                                           // RL12
        end
      end
    end

    // Sync-on-green edge counter
    c_edge = s_q.filt[2] ^ s_q.c_prev;
    s_d.c_prev = s_q.filt[2];
    if (wr2 && !reg_wdata[`B2_SOG]) begin
      s_d.sog_cnt = 6'h00;                                                // RL17
      s_d.green_channel_sync = 1'b0;                                                     // RL17
    end
    if (c_edge) begin
      if (s_d.sog_cnt == `SOG_LAST) begin
        s_d.green_channel_sync = 1'b1;                                                   // RL19
      end else begin
        s_d.sog_cnt = s_d.sog_cnt + 6'h01;                                // RL19
      end
    end

    // Unmixed hsync flag; a read clears it until the next plain period
    if (reg_rd && (reg_addr == `OFS_DETECTION)) begin
      s_d.unmixed = 1'b0;                                                 // RL13
    end
    if (!s_q.vertical_out_source || s_q.sep_q) begin
      s_d.unmixed = 1'b0;                                                 // RL13
    end else if (!s_q.sel_prev && sel_h) begin
      s_d.unmixed = 1'b1;                                                 // RL13
    end

    // Latch-change flag, set beats the clearing write
    if (wr2 && !reg_wdata[`B2_LATCH_CHG]) begin
      s_d.latch_chg = 1'b0;
    end
    if (s_d.sep_q != s_q.sep_q) begin
      s_d.latch_chg = 1'b1;                                               // RL18
    end

    // Pseudo sync generator, positive polarity only
    s_d.ph_cnt = (s_q.ph_cnt == PH_LAST) ? 16'h0000 : s_q.ph_cnt + 16'h0001;
    if (s_q.ph_cnt == PH_LAST) begin
      s_d.pv_cnt = (s_q.pv_cnt == PV_LAST) ? 16'h0000 : s_q.pv_cnt + 16'h0001;
    end

    // Output path
    h_path = (s_q.blank_en && s_q.vertical_out_source && s_q.sep_q) ? 1'b0 : sel_h;      // RL2
    v_path = s_q.vertical_out_source ? s_q.sep_q : s_q.filt[1];                           // RL3
    if (!s_q.pseudo_dis) begin
      h_path = (s_q.ph_cnt < PH_W);                                       // RL15
      v_path = (s_q.pv_cnt < PV_W);                                       // RL15
    end
    h_path = h_path ^ s_q.h_inv;                                          // RL11
    v_path = v_path ^ s_q.v_inv;                                          // RL10
    s_d.hsync_o = s_q.out_dis ? 1'b0 : h_path;                            // RL16
    s_d.vsync_o = s_q.out_dis ? 1'b0 : v_path;                            // RL16
    s_d.clamp_o = (s_q.clamp_cnt != 4'h0) ~^ s_q.clamp_pol;               // RL9

    // Register writes
    if (wr0) begin
      s_d.src_sel  = reg_wdata[`B0_SRC_SEL];
      s_d.blank_en = reg_wdata[`B0_BLANK_EN];
      s_d.vertical_out_source      = reg_wdata[`B0_VOS];
    end
    if (wr1) begin
      s_d.clamp_sel = reg_wdata[`B1_CLAMP_HI:`B1_CLAMP_LO];
      s_d.porch     = reg_wdata[`B1_PORCH];
      s_d.clamp_pol = reg_wdata[`B1_CLAMP_POL];
      s_d.v_inv     = reg_wdata[`B1_V_INV];
      s_d.h_inv     = reg_wdata[`B1_H_INV];
    end
    if (wr2) begin
      s_d.fsync_sel  = reg_wdata[`B2_FSYNC_SEL];
      s_d.pseudo_dis = reg_wdata[`B2_PSEUDO_DIS];
      s_d.out_dis    = reg_wdata[`B2_OUT_DIS];
      s_d.vdd_sel    = reg_wdata[`B2_VDD_SEL];
    end

    // Read data stands for the one cycle after the strobe
    s_d.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `OFS_SEPARATION: s_d.rdata = {s_q.src_sel, s_q.blank_en, s_q.vertical_out_source,
                                      s_q.sep_cnt};                       // RL6
        `OFS_CLAMP_POL:  s_d.rdata = {s_q.clamp_sel, s_q.porch, s_q.clamp_pol,
                                      s_q.v_inv, s_q.h_inv, s_q.pol[1],
                                      s_q.pol[0]};
        `OFS_DETECTION:  s_d.rdata = {s_q.unmixed, 1'b0, s_q.fsync_sel,
                                      s_q.pseudo_dis, s_q.out_dis, s_q.green_channel_sync,
                                      s_q.latch_chg, s_q.vdd_sel};
        `OFS_PORT_READ:  s_d.rdata = {4'h0, s_q.vsync_o, s_q.hsync_o,
                                      s_q.filt[1], s_q.filt[0]};
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.clamp_o <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign hsync_out = s_q.hsync_o;
  assign vsync_out = s_q.vsync_o;
  assign clamp_out = s_q.clamp_o;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sep_count_up_a: assert property ( // RL4
    @(posedge clk_sys) disable iff (!arst_n)
    (samp_tick && sel_h && s_q.sep_cnt != `SEP_MAX)
      |=> s_q.sep_cnt == $past(s_q.sep_cnt) + 5'h01)
    else $error("separation counter did not count up");

  sep_count_sat_a: assert property ( // RL4
    @(posedge clk_sys) disable iff (!arst_n)
    (s_q.sep_cnt == `SEP_MAX && sel_h) |=> s_q.sep_cnt == `SEP_MAX)
    else $error("separation counter left all ones on a high sample");

  latch_level_a: assert property ( // RL5
    @(posedge clk_sys) disable iff (!arst_n)
    (s_q.sep_cnt == `SEP_MAX |-> s_q.sep_q) and
    (s_q.sep_cnt == `SEP_MIN |-> !s_q.sep_q))
    else $error("latch disagrees with counter end value");

  latch_flag_a: assert property ( // RL18
    @(posedge clk_sys) disable iff (!arst_n)
    $changed(s_q.sep_q) |-> s_q.latch_chg)
    else $error("latch change not flagged");

  count_read_a: assert property ( // RL6
    @(posedge clk_sys) disable iff (!arst_n)
    (reg_rd && reg_addr == `OFS_SEPARATION)
      |=> reg_rdata[4:0] == $past(s_q.sep_cnt))
    else $error("counter value not returned on read");

  clamp_wide_a: assert property ( // RL7
    @(posedge clk_sys) disable iff (!arst_n)
    (clamp_start && s_q.clamp_sel == 2'h3) |=> (s_q.clamp_cnt != 4'h0) [*8])
    else $error("widest clamp pulse cut short");

  clamp_off_a: assert property ( // RL9
    @(posedge clk_sys) disable iff (!arst_n)
    (s_q.clamp_sel == 2'h0 && s_q.clamp_cnt == 4'h0) |=> clamp_out == !$past(s_q.clamp_pol))
    else $error("inhibited clamp not at idle level");

  out_inhibit_a: assert property ( // RL16
    @(posedge clk_sys) disable iff (!arst_n)
    s_q.out_dis |=> (!hsync_out && !vsync_out))
    else $error("sync outputs not low while inhibited");

  sog_detect_a: assert property ( // RL19
    @(posedge clk_sys) disable iff (!arst_n)
    (c_edge && s_q.sog_cnt == `SOG_LAST && !(wr2 && !reg_wdata[`B2_SOG])) |=> s_q.green_channel_sync)
    else $error("green sync not flagged after last edge");

  sep_count_down_a: assert property ( // RL4
    @(posedge clk_sys) disable iff (!arst_n)
    (samp_tick && !sel_h && s_q.sep_cnt != `SEP_MIN)
      |=> s_q.sep_cnt == $past(s_q.sep_cnt) - 5'h01)
    else $error("separation counter did not count down");

  sep_floor_a: assert property ( // RL4
    @(posedge clk_sys) disable iff (!arst_n)
    (s_q.sep_cnt == `SEP_MIN && !sel_h) |=> s_q.sep_cnt == `SEP_MIN)
    else $error("separation counter left all zeros on a low sample");

  h_pin_route_a: assert property ( // RL1
    @(posedge clk_sys) disable iff (!arst_n)
    (s_q.pseudo_dis && !s_q.out_dis && !s_q.h_inv && !s_q.blank_en && !s_q.src_sel)
      |=> hsync_out == $past(s_q.filt[0]))
    else $error("separate hsync input not routed");

  c_pin_route_a: assert property ( // RL1
    @(posedge clk_sys) disable iff (!arst_n)
    (s_q.pseudo_dis && !s_q.out_dis && !s_q.h_inv && !s_q.blank_en && s_q.src_sel)
      |=> hsync_out == $past(s_q.filt[2]))
    else $error("composite input not routed");

  v_latch_route_a: assert property ( // RL3
    @(posedge clk_sys) disable iff (!arst_n)
    (s_q.pseudo_dis && !s_q.out_dis && !s_q.v_inv && s_q.vertical_out_source)
      |=> vsync_out == $past(s_q.sep_q))
    else $error("separated vsync not routed");

  v_pin_route_a: assert property ( // RL3
    @(posedge clk_sys) disable iff (!arst_n)
    (s_q.pseudo_dis && !s_q.out_dis && !s_q.v_inv && !s_q.vertical_out_source)
      |=> vsync_out == $past(s_q.filt[1]))
    else $error("vsync input not routed");

  h_blank_a: assert property ( // RL2
    @(posedge clk_sys) disable iff (!arst_n)
    (s_q.pseudo_dis && !s_q.out_dis && !s_q.h_inv && s_q.blank_en && s_q.vertical_out_source && s_q.sep_q)
      |=> !hsync_out)
    else $error("hsync not blanked during extraction");

  h_invert_a: assert property ( // RL11
    @(posedge clk_sys) disable iff (!arst_n)
    (s_q.pseudo_dis && !s_q.out_dis && s_q.h_inv && !s_q.blank_en && !s_q.src_sel)
      |=> hsync_out == !$past(s_q.filt[0]))
    else $error("hsync output not inverted");

  clamp_active_a: assert property ( // RL9
    @(posedge clk_sys) disable iff (!arst_n)
    (s_q.clamp_cnt != 4'h0) |=> clamp_out == $past(s_q.clamp_pol))
    else $error("active clamp at wrong level");

  porch_front_a: assert property ( // RL8
    @(posedge clk_sys) disable iff (!arst_n)
    (!s_q.porch && !s_q.sel_prev && sel_h && s_q.clamp_sel != 2'h0) |=> s_q.clamp_cnt != 4'h0)
    else $error("clamp not started on rising sync");

  porch_back_a: assert property ( // RL8
    @(posedge clk_sys) disable iff (!arst_n)
    (s_q.porch && s_q.sel_prev && !sel_h && s_q.clamp_sel != 2'h0) |=> s_q.clamp_cnt != 4'h0)
    else $error("clamp not started on falling sync");

  latch_keep_a: assert property ( // RL18
    @(posedge clk_sys) disable iff (!arst_n)
    (s_q.latch_chg && !(wr2 && !reg_wdata[`B2_LATCH_CHG])) |=> s_q.latch_chg)
    else $error("latch change flag dropped without a write");

  mixed_clear_a: assert property ( // RL13
    @(posedge clk_sys) disable iff (!arst_n)
    s_q.sep_q |=> !s_q.unmixed)
    else $error("unmixed flag set in a mixed period");

  sog_clear_a: assert property ( // RL17
    @(posedge clk_sys) disable iff (!arst_n)
    (wr2 && !reg_wdata[`B2_SOG] && !c_edge) |=> (s_q.sog_cnt == 6'h00 && !s_q.green_channel_sync))
    else $error("green sync counter not cleared");

endmodule

// ---- tb/sync_source.sv ----
/*
  Model of a graphics source that drives the separate and composite sync pins.
  Assumes the bench sets run and vert after a rising clock edge.
*/
`timescale 1ns/100ps
module sync_source #(
  parameter int HPER = 20,
  parameter int HWID = 8
) (
  input  wire logic clk,
  input  wire logic run,
  input  wire logic vert,
  output logic      hsync = 1'b0,
  output logic      vsync = 1'b0,
  output logic      csync = 1'b0
);
  int pos = 0;
  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Pins move on the falling edge, away from the sampling edge
  always @(negedge clk) begin
    pos = (pos + 1) % HPER;
    hsync <= run && pos < HWID;
    vsync <= vert;
    csync <= (run && pos < HWID) || vert;
  end
endmodule

// ---- tb/tb_video_sync_processor.sv ----
/*
  Self-checking bench of the sync processor with a sync source model.
  Assumes the design package, header and module are compiled first.
*/
`timescale 1ns/100ps
`include "sync_cfg.svh"
module tb_video_sync_processor;
  localparam int PHW = 4;
  localparam int HW  = 8;
  logic       clk_sys   = 1'b0;
  logic       arst_n    = 1'b0;
  logic [1:0] reg_addr  = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic [7:0] reg_rdata;
  logic       hsync_in, vsync_in, csync_in;
  logic       hsync_out, vsync_out, clamp_out;
  logic       run       = 1'b0;
  logic       vert      = 1'b0;
  logic [7:0] rd_v;
  logic       any;
  int         failures  = 0;
  int         n_tests   = 0;
  int         n;
  // ----------------------------------------------------------------
  // Harness
  // ----------------------------------------------------------------
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Short counts keep the pseudo sync and polarity windows quick
  video_sync_processor #(.TIMER_DIV(4), .PSEUDO_H_PERIOD(20), .PSEUDO_H_WIDTH(PHW),
    .PSEUDO_V_LINES(5), .PSEUDO_V_WIDTH(2)) dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .hsync_in(hsync_in), .vsync_in(vsync_in),
    .csync_in(csync_in), .hsync_out(hsync_out), .vsync_out(vsync_out),
    .clamp_out(clamp_out));
  sync_source #(.HPER(20), .HWID(HW)) src (.clk(clk_sys), .run(run), .vert(vert),
    .hsync(hsync_in), .vsync(vsync_in), .csync(csync_in));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string w);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi, input string w);
    n_tests++;
    if (got < lo || got > hi) begin
      failures++;
      $display("FAIL %0t %s took %0d cycles", $time, w, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask
  // Bounded wait for a watched pin to reach lvl; n counts cycles
  task automatic wait_lvl(input int sel, input logic lvl);
    logic s;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1 n++;
      case (sel)
        0: s = vsync_out;
        1: s = clamp_out;
        2: s = hsync_out;
        default: s = hsync_in;
      endcase
      if (n > 3000) begin
        failures++;
        $display("FAIL %0t wait %0d timed out", $time, sel);
        give_verdict();
      end
    end while (s !== lvl);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    for (int a = 0; a < 3; a++) begin
      rd(a[1:0]);
      chk8(rd_v, `REG_RESET, "reset value");
    end
    wait_lvl(2, 1'b1);
    wait_lvl(2, 1'b0);
    chk_rng(n, PHW, PHW, "pseudo hsync width");
    wr(`OFS_SEPARATION, 8'hFF);
    rd(`OFS_SEPARATION);
    chk8(rd_v, 8'hE0, "counter bits read only");
    cyc(150);
    wr(`OFS_CLAMP_POL, 8'hFF);
    rd(`OFS_CLAMP_POL);
    chk8(rd_v, 8'hFF, "idle lines positive");
    wr(`OFS_CLAMP_POL, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_select();
    wr(`OFS_DETECTION, 8'h10);
    wr(`OFS_SEPARATION, 8'h00);
    vert <= 1'b1;
    cyc(10);
    chk8({7'h00, hsync_out}, 8'h00, "hsync pin chosen");
    chk8({7'h00, vsync_out}, 8'h01, "vsync pin chosen");
    rd(`OFS_PORT_READ);
    chk8(rd_v, 8'h0A, "port read");
    wr(`OFS_SEPARATION, 8'h80);
    cyc(8);
    chk8({7'h00, hsync_out}, 8'h01, "composite chosen");
    wr(`OFS_SEPARATION, 8'hA0);
    cyc(4);
    chk8({7'h00, vsync_out}, 8'h00, "latch chosen");
    wr(`OFS_CLAMP_POL, 8'h0C);
    cyc(4);
    chk8({7'h00, hsync_out}, 8'h00, "hsync inverted");
    chk8({7'h00, vsync_out}, 8'h01, "vsync inverted");
    wr(`OFS_DETECTION, 8'h18);
    cyc(4);
    chk8({6'h00, hsync_out, vsync_out}, 8'h00, "outputs inhibited");
    wr(`OFS_DETECTION, 8'h10);
    wr(`OFS_CLAMP_POL, 8'h00);
    vert <= 1'b0;
    $display("test select done");
  endtask
  task automatic t_sep();
    wr(`OFS_SEPARATION, 8'hA0);
    for (int fs = 0; fs < 2; fs++) begin
      wr(`OFS_DETECTION, fs ? 8'h30 : 8'h10);
      cyc(150);
      vert <= 1'b1;
      wait_lvl(0, 1'b1);
      chk_rng(n, fs ? 58 : 88, fs ? 72 : 102, "rise to all ones");
      cyc(40);
      rd(`OFS_SEPARATION);
      chk8(rd_v, 8'hBF, "counter saturates high");
      rd(`OFS_DETECTION);
      chk8(rd_v & 8'h02, 8'h02, "latch change seen");
      wr(`OFS_SEPARATION, 8'hE0);
      cyc(4);
      chk8({7'h00, hsync_out}, 8'h00, "hsync blanked");
      wr(`OFS_SEPARATION, 8'hA0);
      cyc(4);
      chk8({7'h00, hsync_out}, 8'h01, "hsync unblanked");
      vert <= 1'b0;
      cyc(40);
      chk8({7'h00, vsync_out}, 8'h01, "latch holds");
      wait_lvl(0, 1'b0);
      rd(`OFS_SEPARATION);
      chk8(rd_v, 8'hA0, "counter saturates low");
      wr(`OFS_DETECTION, fs ? 8'h30 : 8'h10);
      rd(`OFS_DETECTION);
      chk8(rd_v & 8'h02, 8'h00, "latch change cleared");
    end
    $display("test separation done");
  endtask
  task automatic t_clamp();
    wr(`OFS_SEPARATION, 8'h00);
    wr(`OFS_DETECTION, 8'h10);
    run <= 1'b1;
    for (int s = 1; s < 4; s++) begin
      for (int p = 0; p < 2; p++) begin
        wr(`OFS_CLAMP_POL, {s[1:0], p[0], 1'b1, 4'h0});
        wait_lvl(3, 1'b0);
        wait_lvl(3, 1'b1);
        wait_lvl(1, 1'b1);
        chk_rng(n, p ? HW + 2 : 2, p ? HW + 8 : 8, "clamp start");
        wait_lvl(1, 1'b0);
        chk_rng(n, 1 << s, 1 << s, "clamp width");
      end
    end
    wr(`OFS_CLAMP_POL, 8'hC0);
    wait_lvl(3, 1'b0);
    wait_lvl(3, 1'b1);
    wait_lvl(1, 1'b0);
    wait_lvl(1, 1'b1);
    chk_rng(n, 8, 8, "low clamp width");
    wr(`OFS_CLAMP_POL, 8'h10);
    any = 1'b0;
    repeat (60) begin
      cyc(1);
      any |= clamp_out;
    end
    chk8({7'h00, any}, 8'h00, "clamp inhibited");
    wr(`OFS_CLAMP_POL, 8'h00);
    $display("test clamp done");
  endtask
  task automatic t_detect();
    cyc(200);
    rd(`OFS_CLAMP_POL);
    chk8(rd_v & 8'h03, 8'h03, "both positive");
    vert <= 1'b1;
    cyc(200);
    rd(`OFS_CLAMP_POL);
    chk8(rd_v & 8'h03, 8'h01, "vsync negative");
    vert <= 1'b0;
    wr(`OFS_SEPARATION, 8'hA0);
    cyc(150);
    rd(`OFS_DETECTION);
    chk8(rd_v & 8'h80, 8'h80, "unmixed periods");
    vert <= 1'b1;
    cyc(150);
    rd(`OFS_DETECTION);
    chk8(rd_v & 8'h80, 8'h00, "mixed periods");
    vert <= 1'b0;
    cyc(150);
    wr(`OFS_DETECTION, 8'h10);
    rd(`OFS_DETECTION);
    chk8(rd_v & 8'h04, 8'h00, "green flag cleared");
    cyc(280);
    rd(`OFS_DETECTION);
    chk8(rd_v & 8'h04, 8'h00, "under 64 edges");
    cyc(400);
    rd(`OFS_DETECTION);
    chk8(rd_v & 8'h04, 8'h04, "green sync found");
    $display("test detect done");
  endtask
  initial begin
    cyc(8);
    arst_n <= 1'b1;
    t_reset();
    t_select();
    t_sep();
    t_clamp();
    t_detect();
    give_verdict();
  end
endmodule
